// ==== hdl/mem_sched.sv ====
// address scheduler, banked store and data distributor
`default_nettype none
module mem_sched import mem_sched_pkg::*; #(
  parameter int LAT = ACC_LAT,
  parameter int FDEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cpu_valid_i,
  input wire req_s cpu_req_i,
  output logic cpu_ack_o,
  output logic cpu_rsp_valid_o,
  output req_s cpu_rsp_o,
  input wire logic pp_rd_valid_i,
  input wire logic [PP_ID_W-1:0] pp_rd_id_i,
  input wire logic [ADDR_W-1:0] pp_rd_addr_i,
  output logic pp_rd_ack_o,
  input wire logic pp_wr_valid_i,
  input wire logic [PP_ID_W-1:0] pp_wr_id_i,
  input wire logic [ADDR_W-1:0] pp_wr_addr_i,
  input wire logic [PPW-1:0] pp_wr_word_i,
  output logic pp_wr_ack_o,
  output logic pp_out_valid_o,
  output logic [PP_ID_W-1:0] pp_out_id_o,
  output logic [PPW-1:0] pp_out_word_o,
  output logic [CNT_W-1:0] pp_out_idx_o
);
  // ----------------------------------------------------------------
  // minor-cycle enable
  // ----------------------------------------------------------------
  logic [3:0] div_reg;
  logic tick;
  assign tick = div_reg == 4'(MINOR_CYC - 1);
  always_ff @(posedge clk_i) begin
    if (!rstn_i || tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // banks
  // ----------------------------------------------------------------
  // flat store, bank is low field
  logic [DATA_W-1:0] store [NBANK*BANK_WORDS];
  logic [BUSY_W-1:0] busy_reg [NBANK];
  logic [NBANK-1:0] idle;
  logic issue_v;
  logic issue_acc;
  req_s issue_req;
  logic [BANK_W-1:0] issue_bank;

  assign issue_bank = issue_req.addr[BANK_W-1:0];
  // only the idle addressed bank takes it
  assign issue_acc = issue_v && idle[issue_bank];

  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    assign idle[b] = busy_reg[b] == '0;
    always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
        busy_reg[b] <= '0;
      end else if (tick) begin
        if (issue_acc && issue_bank == BANK_W'(b)) begin
          busy_reg[b] <= BUSY_W'(MAJOR_MINORS - 1);
        end else if (busy_reg[b] != '0) begin
          busy_reg[b] <= busy_reg[b] - 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // retry store: issued copies wait out the accept latency
  // ----------------------------------------------------------------
  logic pv_reg [LAT];
  logic pa_reg [LAT];
  req_s pr_reg [LAT];
  logic tail_v;
  logic tail_acc;
  req_s tail;
  logic fifo_in_ready;
  logic done;
  logic retry;

  assign tail_v = pv_reg[LAT-1];
  assign tail_acc = pa_reg[LAT-1];
  assign tail = pr_reg[LAT-1];
  // a full fifo turns a read into a retry, so the source is stalled
  assign done = tail_v && tail_acc &&
      (tail.tag.typ == REF_WRITE || fifo_in_ready);
  assign retry = tail_v && !done;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      for (int i = 0; i < LAT; i++) begin
        pv_reg[i] <= 1'b0;
        pa_reg[i] <= 1'b0;
        pr_reg[i] <= '0;
      end
    end else if (tick) begin
      // acceptance seen a fixed LAT later
      pv_reg[0] <= issue_v;
      pa_reg[0] <= issue_acc;
      pr_reg[0] <= issue_req;
      for (int i = 1; i < LAT; i++) begin
        pv_reg[i] <= pv_reg[i-1];
        pa_reg[i] <= pa_reg[i-1];
        pr_reg[i] <= pr_reg[i-1];
      end
    end
  end

  // ----------------------------------------------------------------
  // packing slots
  // ----------------------------------------------------------------
  logic [SLOTS-1:0] kv_reg;
  logic [PP_ID_W-1:0] kid_reg [SLOTS];
  logic [ADDR_W-1:0] kad_reg [SLOTS];
  logic [DATA_W-1:0] kw_reg [SLOTS];
  logic [CNT_W-1:0] kc_reg [SLOTS];
  logic k_found;
  logic [1:0] k_sel;
  logic k_full;
  logic [1:0] k_full_sel;
  logic wr_take;

  always_comb begin
    k_found = 1'b0;
    k_sel = '0;
    k_full = 1'b0;
    k_full_sel = '0;
    for (int s = SLOTS - 1; s >= 0; s--) begin
      if (!kv_reg[s] && !k_found) begin
        k_sel = 2'(s);
      end
      if (kv_reg[s] && kc_reg[s] == CNT_W'(PACK_N)) begin
        k_full = 1'b1;
        k_full_sel = 2'(s);
      end
    end
    k_found = kv_reg != '1;
    // an open slot owned by this pp wins over a fresh one
    for (int s = 0; s < SLOTS; s++) begin
      if (kv_reg[s] && kid_reg[s] == pp_wr_id_i &&
          kc_reg[s] != CNT_W'(PACK_N)) begin
        k_found = 1'b1;
        k_sel = 2'(s);
      end
    end
  end

  // ack guard relies on requester holding
  assign wr_take = tick && pp_wr_valid_i && !pp_wr_ack_o && k_found;

  // ----------------------------------------------------------------
  // issue arbitration
  // ----------------------------------------------------------------
  logic cpu_take;
  logic pp_valid;
  logic pp_take;
  req_s pp_req;

  assign cpu_take = cpu_valid_i && !cpu_ack_o && !retry;
  // one shared write path, reads share it too
  assign pp_valid = k_full || (pp_rd_valid_i && !pp_rd_ack_o);
  // waiting retry holds off new requests
  assign pp_take = pp_valid && !retry && !cpu_take;

  always_comb begin
    pp_req.tag.src = SRC_PP;
    pp_req.tag.pp = k_full ? kid_reg[k_full_sel] : pp_rd_id_i;
    pp_req.tag.typ = k_full ? REF_WRITE : REF_READ;
    pp_req.addr = k_full ? kad_reg[k_full_sel] : pp_rd_addr_i;
    pp_req.data = k_full ? kw_reg[k_full_sel] : '0;
  end

  // at most one address per minor
  // retry, then cpu, then pp path
  always_comb begin
    issue_v = 1'b0;
    issue_req = pp_req;
    if (retry) begin
      issue_v = 1'b1;
      issue_req = tail;
    end else if (cpu_take) begin
      issue_v = 1'b1;
      issue_req = cpu_req_i;
    end else if (pp_take) begin
      issue_v = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cpu_ack_o <= 1'b0;
      pp_rd_ack_o <= 1'b0;
      pp_wr_ack_o <= 1'b0;
    end else begin
      cpu_ack_o <= tick && cpu_take;
      pp_rd_ack_o <= tick && pp_take && !k_full;
      pp_wr_ack_o <= wr_take;
    end
  end

  // five 12-bit words fill one word
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      kv_reg <= '0;
      for (int s = 0; s < SLOTS; s++) begin
        kid_reg[s] <= '0;
        kad_reg[s] <= '0;
        kw_reg[s] <= '0;
        kc_reg[s] <= '0;
      end
    end else begin
      if (tick && pp_take && k_full) begin
        kv_reg[k_full_sel] <= 1'b0;
      end
      if (wr_take) begin
        kv_reg[k_sel] <= 1'b1;
        kid_reg[k_sel] <= pp_wr_id_i;
        kw_reg[k_sel] <= {kw_reg[k_sel][DATA_W-PPW-1:0], pp_wr_word_i};
        if (!kv_reg[k_sel]) begin
          kad_reg[k_sel] <= pp_wr_addr_i;
          kc_reg[k_sel] <= CNT_W'(1);
        end else begin
          kc_reg[k_sel] <= kc_reg[k_sel] + 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // completion: data moves only when acceptance returns
  // ----------------------------------------------------------------
  logic fifo_in_valid;
  req_s rsp;

  always_comb begin
    rsp = tail;
    rsp.data = store[tail.addr];
  end
  // one word per minor on the data path
  assign fifo_in_valid = tick && tail_v && tail_acc &&
      tail.tag.typ != REF_WRITE;

  // write data rides in the retry store
  // exchange returns old word, stores new
  always_ff @(posedge clk_i) begin
    if (tick && done && tail.tag.typ != REF_READ) begin
      store[tail.addr] <= tail.data;
    end
  end

  // ----------------------------------------------------------------
  // read-data buffer and routing
  // ----------------------------------------------------------------
  logic fifo_out_valid;
  logic fifo_out_ready;
  req_s head;
  logic [SLOTS-1:0] uv_reg;
  logic u_free;
  logic [1:0] u_sel;
  logic u_busy;
  logic [1:0] u_emit;

  sched_fifo #(
    .WIDTH(REQ_W),
    .DEPTH(FDEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rsp),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_out_ready),
    .out_data_o(head)
  );

  always_comb begin
    u_free = uv_reg != '1;
    u_busy = uv_reg != '0;
    u_sel = '0;
    u_emit = '0;
    for (int s = SLOTS - 1; s >= 0; s--) begin
      if (!uv_reg[s]) begin
        u_sel = 2'(s);
      end
      if (uv_reg[s]) begin
        u_emit = 2'(s);
      end
    end
  end

  // replies go by tag, not by order
  // leaves on ticks only, so replies never run back to back
  assign fifo_out_ready = tick && (head.tag.src == SRC_CPU || u_free);

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cpu_rsp_valid_o <= 1'b0;
      cpu_rsp_o <= '0;
    end else begin
      cpu_rsp_valid_o <= tick && fifo_out_valid && head.tag.src == SRC_CPU;
      // held between replies, empty fifo head is never shown
      if (tick && fifo_out_valid && head.tag.src == SRC_CPU) begin
        cpu_rsp_o <= head;
      end
    end
  end

  // ----------------------------------------------------------------
  // unpacking slots
  // ----------------------------------------------------------------
  logic [PP_ID_W-1:0] uid_reg [SLOTS];
  logic [DATA_W-1:0] uw_reg [SLOTS];
  logic [CNT_W-1:0] uc_reg [SLOTS];
  logic u_load;

  assign u_load = tick && fifo_out_valid && head.tag.src == SRC_PP && u_free;

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      uv_reg <= '0;
      pp_out_valid_o <= 1'b0;
      pp_out_id_o <= '0;
      pp_out_word_o <= '0;
      pp_out_idx_o <= '0;
      for (int s = 0; s < SLOTS; s++) begin
        uid_reg[s] <= '0;
        uw_reg[s] <= '0;
        uc_reg[s] <= '0;
      end
    end else begin
      pp_out_valid_o <= tick && u_busy;
      if (tick && u_busy) begin
        pp_out_id_o <= uid_reg[u_emit];
        pp_out_word_o <= uw_reg[u_emit][DATA_W-1 -: PPW];
        pp_out_idx_o <= uc_reg[u_emit];
        uw_reg[u_emit] <= {uw_reg[u_emit][DATA_W-PPW-1:0], PPW'(0)};
        uc_reg[u_emit] <= uc_reg[u_emit] + 1'b1;
        if (uc_reg[u_emit] == CNT_W'(PACK_N - 1)) begin
          uv_reg[u_emit] <= 1'b0;
        end
      end
      if (u_load) begin
        uv_reg[u_sel] <= 1'b1;
        uid_reg[u_sel] <= head.tag.pp;
        uw_reg[u_sel] <= head.data;
        uc_reg[u_sel] <= '0;
      end
    end
  end
endmodule : mem_sched
`default_nettype wire

// ==== hdl/mem_sched_pkg.sv ====
// shared types and constants for the interleaved memory scheduler
`default_nettype none
package mem_sched_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 50;
  localparam int MINOR_NS = 100;
  localparam int MINOR_CYC = (MINOR_NS + CLK_NS - 1) / CLK_NS;
  localparam int MAJOR_MINORS = 10;
  localparam int ACC_LAT = 3;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int NBANK = 32;
  localparam int BANK_W = 5;
  localparam int BANK_WORDS = 4096;
  localparam int ADDR_W = 17;
  localparam int DATA_W = 60;
  localparam int PPW = 12;
  localparam int PP_CNT = 10;
  localparam int PP_ID_W = 4;
  localparam int PACK_N = 5;
  localparam int SLOTS = 4;
  localparam int FIFO_DEPTH = 8;
  localparam int BUSY_W = 4;
  localparam int CNT_W = 3;

  typedef enum logic [1:0] {REF_READ, REF_WRITE, REF_XJ} ref_e;
  typedef enum logic {SRC_CPU, SRC_PP} src_e;

  typedef struct packed {
    src_e src;
    logic [PP_ID_W-1:0] pp;
    ref_e typ;
  } tag_s;

  typedef struct packed {
    tag_s tag;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } req_s;

  localparam int REQ_W = $bits(req_s);
endpackage : mem_sched_pkg
`default_nettype wire

// ==== hdl/sched_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`default_nettype none
module sched_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  assign in_ready_o = cnt_reg != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_reg != '0;
  assign out_data_o = mem_reg[rd_reg];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sched_fifo
`default_nettype wire

// ==== test/cpu_requester.sv ====
// central processor requester model, holds each request until taken
`default_nettype none
module cpu_requester import mem_sched_pkg::*; (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic go_i,
  input wire req_s req_i,
  input wire logic ack_i,
  output logic valid_o,
  output req_s req_o
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(negedge clk_i) begin
    if (!rstn_i) begin
      valid_o <= 1'b0;
      req_o <= '0;
    end else if (valid_o && ack_i) begin
      valid_o <= 1'b0;
      // released fields never show the old request
      req_o <= ~req_o;
    end else if (go_i && !valid_o) begin
      valid_o <= 1'b1;
      req_o <= req_i;
    end
  end
endmodule : cpu_requester
`default_nettype wire

// ==== test/mem_sched_assertions.sv ====
// concurrent checks on the memory scheduler ports
`default_nettype none
module mem_sched_assertions import mem_sched_pkg::*; #(
  parameter int LAT = ACC_LAT,
  parameter int FDEPTH = FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic cpu_valid_i,
  input wire req_s cpu_req_i,
  input wire logic cpu_ack_o,
  input wire logic cpu_rsp_valid_o,
  input wire req_s cpu_rsp_o,
  input wire logic pp_rd_valid_i,
  input wire logic [PP_ID_W-1:0] pp_rd_id_i,
  input wire logic [ADDR_W-1:0] pp_rd_addr_i,
  input wire logic pp_rd_ack_o,
  input wire logic pp_wr_valid_i,
  input wire logic [PP_ID_W-1:0] pp_wr_id_i,
  input wire logic [ADDR_W-1:0] pp_wr_addr_i,
  input wire logic [PPW-1:0] pp_wr_word_i,
  input wire logic pp_wr_ack_o,
  input wire logic pp_out_valid_o,
  input wire logic [PP_ID_W-1:0] pp_out_id_o,
  input wire logic [PPW-1:0] pp_out_word_o,
  input wire logic [CNT_W-1:0] pp_out_idx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ----------------------------------------------------------------
  // issue side
  // ----------------------------------------------------------------
  one_issue_a: assert property (
    (cpu_ack_o || pp_rd_ack_o) |=> !(cpu_ack_o || pp_rd_ack_o))
    else $error("two issues inside one minor cycle");
  cpu_first_a: assert property (
    pp_rd_ack_o |-> !$past(cpu_valid_i && !cpu_ack_o))
    else $error("pp read taken over a waiting cpu request");
  cpu_cause_a: assert property (
    cpu_ack_o |-> $past(cpu_valid_i))
    else $error("cpu ack without request");
  rd_cause_a: assert property (
    pp_rd_ack_o |-> $past(pp_rd_valid_i))
    else $error("pp read ack without request");
  wr_cause_a: assert property (
    pp_wr_ack_o |-> $past(pp_wr_valid_i) ##1 !pp_wr_ack_o)
    else $error("pp write ack without request");
  // ----------------------------------------------------------------
  // reply side
  // ----------------------------------------------------------------
  rsp_single_a: assert property (
    cpu_rsp_valid_o |=> !cpu_rsp_valid_o)
    else $error("reply held over two clocks");
  rsp_kind_a: assert property (
    cpu_rsp_valid_o |-> cpu_rsp_o.tag.typ != REF_WRITE)
    else $error("reply carries a write tag");
  unpack_field_a: assert property (
    pp_out_valid_o |-> pp_out_idx_o < 3'h5 && pp_out_id_o < 4'hA)
    else $error("unpack index or id out of range");
  unpack_pace_a: assert property (
    pp_out_valid_o |=> !pp_out_valid_o)
    else $error("unpacked words closer than a minor cycle");
  cover property (cpu_rsp_valid_o && cpu_rsp_o.tag.typ == REF_XJ);
  cover property (pp_out_valid_o && pp_out_idx_o == 3'h4);
  cover property (pp_wr_ack_o ##2 pp_wr_ack_o);
endmodule : mem_sched_assertions
`default_nettype wire

// ==== test/mem_sched_bench.sv ====
// self-checking bench for the memory scheduler
`default_nettype none
module mem_sched_bench import mem_sched_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic go = 1'b0;
  req_s cmd = '0;
  req_s cpu_req_i, cpu_rsp_o;
  logic cpu_valid_i, cpu_ack_o, cpu_rsp_valid_o, pp_rd_ack_o, pp_wr_ack_o;
  logic pp_rd_valid_i = 1'b0;
  logic pp_wr_valid_i = 1'b0;
  logic [PP_ID_W-1:0] pp_rd_id_i = '0, pp_wr_id_i = '0, pp_out_id_o;
  logic [ADDR_W-1:0] pp_rd_addr_i = '0, pp_wr_addr_i = '0;
  logic [PPW-1:0] pp_wr_word_i = '0, pp_out_word_o;
  logic pp_out_valid_o;
  logic [CNT_W-1:0] pp_out_idx_o;
  int bad_count = 0;
  int samples_checked = 0;
  req_s rsp_q[$];
  logic [18:0] out_q[$];
  always #25 clk_i = ~clk_i;
  cpu_requester cpu_requester_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .go_i(go), .req_i(cmd), .ack_i(cpu_ack_o), .valid_o(cpu_valid_i),
    .req_o(cpu_req_i));
  mem_sched mem_sched_inst (.clk_i(clk_i), .rstn_i(rstn_i),
    .cpu_valid_i(cpu_valid_i), .cpu_req_i(cpu_req_i), .cpu_ack_o(cpu_ack_o),
    .cpu_rsp_valid_o(cpu_rsp_valid_o), .cpu_rsp_o(cpu_rsp_o),
    .pp_rd_valid_i(pp_rd_valid_i), .pp_rd_id_i(pp_rd_id_i),
    .pp_rd_addr_i(pp_rd_addr_i), .pp_rd_ack_o(pp_rd_ack_o),
    .pp_wr_valid_i(pp_wr_valid_i), .pp_wr_id_i(pp_wr_id_i),
    .pp_wr_addr_i(pp_wr_addr_i), .pp_wr_word_i(pp_wr_word_i),
    .pp_wr_ack_o(pp_wr_ack_o), .pp_out_valid_o(pp_out_valid_o),
    .pp_out_id_o(pp_out_id_o), .pp_out_word_o(pp_out_word_o),
    .pp_out_idx_o(pp_out_idx_o));
  // one-clock pulses, caught mid-cycle where they are settled
  always @(negedge clk_i) begin
    if (cpu_rsp_valid_o === 1'b1) rsp_q.push_back(cpu_rsp_o);
    if (pp_out_valid_o === 1'b1) begin
      out_q.push_back({pp_out_idx_o, pp_out_id_o, pp_out_word_o});
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic cpu_op(input ref_e t, input logic [16:0] a,
      input logic [59:0] d);
    int n;
    @(negedge clk_i);
    go <= 1'b1;
    cmd <= '{tag: '{src: SRC_CPU, pp: 4'h0, typ: t}, addr: a, data: d};
    @(negedge clk_i);
    go <= 1'b0;
    n = 0;
    while (cpu_ack_o !== 1'b1 && n < 200) begin
      @(negedge clk_i);
      n++;
    end
    check({63'h0, cpu_ack_o}, 64'h1);
  endtask : cpu_op
  task automatic pp_req(input logic wr, input logic [3:0] id,
      input logic [16:0] a, input logic [11:0] w);
    int n;
    @(negedge clk_i);
    pp_wr_valid_i <= wr;
    pp_rd_valid_i <= !wr;
    {pp_wr_id_i, pp_rd_id_i, pp_wr_addr_i, pp_rd_addr_i} <= {id, id, a, a};
    pp_wr_word_i <= w;
    n = 0;
    do begin
      @(negedge clk_i);
      n++;
    end while ((wr ? pp_wr_ack_o : pp_rd_ack_o) !== 1'b1 && n < 200);
    pp_wr_valid_i <= 1'b0;
    pp_rd_valid_i <= 1'b0;
    pp_wr_word_i <= ~w;
    check({63'h0, n < 200}, 64'h1);
  endtask : pp_req
  task automatic expect_rsp(input logic [16:0] a, input logic [59:0] d,
      input ref_e t);
    int k;
    k = -1;
    for (int n = 0; n < 400 && k < 0; n++) begin
      @(negedge clk_i);
      foreach (rsp_q[i]) if (k < 0 && rsp_q[i].addr === a) k = i;
    end
    check({63'h0, k >= 0}, 64'h1);
    if (k >= 0) begin
      check({4'h0, rsp_q[k].data}, {4'h0, d});
      check({62'h0, rsp_q[k].tag.typ}, {62'h0, t});
      rsp_q.delete(k);
    end
  endtask : expect_rsp
  // bank stays busy ten minors, plus accept latency
  task automatic settle();
    repeat (48) @(negedge clk_i);
  endtask : settle
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_interleave();
    for (int i = 0; i < 4; i++) cpu_op(REF_WRITE, 17'(i), 60'hA50 + 60'(i));
    settle();
    for (int i = 0; i < 4; i++) cpu_op(REF_READ, 17'(i), '0);
    for (int i = 0; i < 4; i++) expect_rsp(17'(i), 60'hA50 + 60'(i), REF_READ);
  endtask : t_interleave
  task automatic t_conflict();
    cpu_op(REF_WRITE, 17'h00020, 60'h111);
    cpu_op(REF_WRITE, 17'h00040, 60'h222);
    settle();
    cpu_op(REF_READ, 17'h00040, '0);
    cpu_op(REF_READ, 17'h00020, '0);
    cpu_op(REF_READ, 17'h00001, '0);
    expect_rsp(17'h00001, 60'hA51, REF_READ);
    expect_rsp(17'h00020, 60'h111, REF_READ);
    expect_rsp(17'h00040, 60'h222, REF_READ);
  endtask : t_conflict
  task automatic t_exchange();
    cpu_op(REF_XJ, 17'h00003, 60'hBAD);
    expect_rsp(17'h00003, 60'hA53, REF_XJ);
    settle();
    cpu_op(REF_READ, 17'h00003, '0);
    expect_rsp(17'h00003, 60'hBAD, REF_READ);
  endtask : t_exchange
  task automatic t_pack();
    logic [59:0] exp;
    exp = '0;
    for (int i = 0; i < 5; i++) begin
      pp_req(1'b1, 4'h3, 17'h00105, 12'hA00 + 12'(i));
      exp = {exp[47:0], 12'hA00 + 12'(i)};
    end
    settle();
    cpu_op(REF_READ, 17'h00105, '0);
    expect_rsp(17'h00105, exp, REF_READ);
    pp_req(1'b0, 4'h9, 17'h00105, 12'h000);
    for (int n = 0; n < 400 && out_q.size() < 5; n++) @(negedge clk_i);
    check(64'(out_q.size()), 64'h5);
    for (int i = 0; i < 5 && i < out_q.size(); i++) begin
      check({45'h0, out_q[i]},
          {45'h0, 3'(i), 4'h9, exp[59-12*i -: 12]});
    end
  endtask : t_pack
  initial begin
    repeat (20) @(negedge clk_i);
    rstn_i = 1'b1;
    t_interleave();
    t_conflict();
    t_exchange();
    t_pack();
    stop_test();
  end
  // about twenty times the expected run
  initial begin
    #(8000 * 50);
    bad_count++;
    stop_test();
  end
endmodule : mem_sched_bench
bind mem_sched mem_sched_assertions #(.LAT(LAT), .FDEPTH(FDEPTH))
  mem_sched_assertions_inst (.clk_i(clk_i), .rstn_i(rstn_i),
  .cpu_valid_i(cpu_valid_i), .cpu_req_i(cpu_req_i), .cpu_ack_o(cpu_ack_o),
  .cpu_rsp_valid_o(cpu_rsp_valid_o), .cpu_rsp_o(cpu_rsp_o),
  .pp_rd_valid_i(pp_rd_valid_i), .pp_rd_id_i(pp_rd_id_i),
  .pp_rd_addr_i(pp_rd_addr_i), .pp_rd_ack_o(pp_rd_ack_o),
  .pp_wr_valid_i(pp_wr_valid_i), .pp_wr_id_i(pp_wr_id_i),
  .pp_wr_addr_i(pp_wr_addr_i), .pp_wr_word_i(pp_wr_word_i),
  .pp_wr_ack_o(pp_wr_ack_o), .pp_out_valid_o(pp_out_valid_o),
  .pp_out_id_o(pp_out_id_o), .pp_out_word_o(pp_out_word_o),
  .pp_out_idx_o(pp_out_idx_o));
`default_nettype wire
